// file: include/rost_pkg.sv
// rost_pkg: constants and types for the relay output and speed trip block.
// assumes a single 125 MHz system clock and an apb register bus.
package rost_pkg;

	// clock and time base
	localparam int unsigned CLK_HZ        = 125_000_000;
	localparam int unsigned TICK_SEC      = 1;                  // time base period, seconds
	localparam int unsigned SEC_CYCLES    = CLK_HZ * TICK_SEC;  // cycles per second tick

	// apb register byte offsets
	localparam logic [7:0] OFS_RELAY_CFG  = 8'h00;
	localparam logic [7:0] OFS_TACH_CFG   = 8'h04;
	localparam logic [7:0] OFS_SCALE_LO   = 8'h08;
	localparam logic [7:0] OFS_SCALE_HI   = 8'h0C;
	localparam logic [7:0] OFS_RAMP       = 8'h10;
	localparam logic [7:0] OFS_UNDER_PT   = 8'h14;
	localparam logic [7:0] OFS_OVER_PT    = 8'h18;
	localparam logic [7:0] OFS_TRIP_DLY   = 8'h1C;
	localparam logic [7:0] OFS_ROUTE      = 8'h20;
	localparam logic [7:0] OFS_STATUS     = 8'h24;
	localparam logic [7:0] OFS_SAMPLE     = 8'h28;
	localparam logic [7:0] OFS_INT_STAT   = 8'h2C;
	localparam logic [7:0] OFS_INT_MASK   = 8'h30;

	// field positions
	localparam int unsigned RELAY_CFG_FS_LSB  = 0;  // [7:0] fail-safe per relay
	localparam int unsigned RELAY_CFG_LAT_LSB = 8;  // [15:8] latching per relay
	localparam int unsigned TACH_CFG_SCALE    = 0;  // scale enable
	localparam int unsigned TACH_CFG_MODE_LSB = 1;  // [2:1] trip mode
	localparam int unsigned ROUTE_TRIP        = 0;  // tach trip to trip relay
	localparam int unsigned ROUTE_USER_LSB    = 4;  // [7:4] tach trip to relays five..eight
	localparam int unsigned IRQ_TACH_TRIP     = 0;
	localparam int unsigned IRQ_SAMPLE        = 1;
	localparam int unsigned IRQ_RELAY         = 2;

	// relay indices
	localparam int unsigned RELAY_TRIP    = 0;
	localparam int unsigned RELAY_ALARM   = 1;
	localparam int unsigned RELAY_FACT3   = 2;
	localparam int unsigned RELAY_FACT4   = 3;

	// trip mode encodings
	localparam logic [1:0] MODE_DISABLED  = 2'h0;
	localparam logic [1:0] MODE_UNDER     = 2'h1;
	localparam logic [1:0] MODE_OVER      = 2'h2;

	// values after reset and limits
	localparam logic [7:0]  RST_FAILSAFE  = 8'h00;
	localparam logic [7:0]  RST_LATCH     = 8'h01;   // trip relay latches
	localparam logic [7:0]  RST_ROUTE     = 8'h01;   // tach trip to trip relay
	localparam logic [11:0] RST_SCALE_LO  = 12'h000;
	localparam logic [11:0] RST_SCALE_HI  = 12'h7D0; // 2000 rpm
	localparam logic [11:0] RST_UNDER_PT  = 12'h672; // 1650 rpm
	localparam logic [11:0] RST_OVER_PT   = 12'h73A; // 1850 rpm
	localparam logic [11:0] RPM_MAX       = 12'hE10; // 3600 rpm
	localparam logic [6:0]  RST_RAMP      = 7'h14;   // 20 s
	localparam logic [6:0]  RAMP_MIN      = 7'h01;
	localparam logic [6:0]  RAMP_MAX      = 7'h78;   // 120 s
	localparam logic [6:0]  RST_TRIP_DLY  = 7'h01;   // 1 s
	localparam logic [6:0]  DLY_MIN       = 7'h01;
	localparam logic [6:0]  DLY_MAX       = 7'h3C;   // 60 s
	localparam logic [11:0] CODE_FULL     = 12'hFFF; // adc code at 20 mA

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RAMP,
		ST_SAMPLE,
		ST_PERSIST,
		ST_TRIPPED,
		ST_DONE
	} rost_tach_t;

endpackage

// file: hdl/rost_relay_chan.sv
// rost_relay_chan: one output relay with fail-safe and latching options.
// assumes i_cond is a synchronous level and i_man_rst a one-cycle pulse.
module rost_relay_chan (
	input  wire logic i_clk_sys,
	input  wire logic i_sys_rst,
	input  wire logic i_cond,
	input  wire logic i_fail_safe,
	input  wire logic i_latch,
	input  wire logic i_man_rst,
	output logic      o_active,
	output logic      o_coil
);
	import rost_pkg::*;

	logic latched_reg;
	logic latched_next;
	logic active_w;

	// a latched relay holds past its cause; reset releases it only once the cause is gone
	assign latched_next = !i_latch ? 1'b0 :
	                      (i_cond ? 1'b1 :
	                       (i_man_rst ? 1'b0 : latched_reg));
	assign active_w     = i_cond | latched_reg;

	// coil flop: cleared at reset, so a fail-safe coil only pulls in once powered up
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			latched_reg <= 1'b0;
			o_active    <= 1'b0;
			o_coil      <= 1'b0;
		end else begin
			latched_reg <= latched_next;
			o_active    <= active_w;
			o_coil      <= i_fail_safe ? !active_w : active_w;
		end
	end

endmodule

// file: hdl/rost_rpm_scale.sv
// rost_rpm_scale: converts the speed input code to rpm between two scale points.
// assumes code 0 means 4 mA and full code means 20 mA, both synchronous.
module rost_rpm_scale (
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	input  wire logic [11:0] i_code,
	input  wire logic [11:0] i_rpm_lo,
	input  wire logic [11:0] i_rpm_hi,
	output logic      [11:0] o_rpm
);
	import rost_pkg::*;

	logic signed [12:0] diff_w;
	logic signed [25:0] prod_w;
	logic signed [25:0] quot_w;
	logic signed [25:0] sum_w;
	logic        [11:0] rpm_next;

	// a reversed scale (high below low) is allowed and gives a falling slope
	assign diff_w   = $signed({1'b0, i_rpm_hi}) - $signed({1'b0, i_rpm_lo});
	assign prod_w   = 26'(diff_w * $signed({1'b0, i_code}));
	assign quot_w   = prod_w / $signed({14'h0000, CODE_FULL});
	assign sum_w    = quot_w + $signed({14'h0000, i_rpm_lo});
	assign rpm_next = (sum_w < 0) ? 12'h000 : sum_w[11:0];

	// registered to cut the divider path from the comparators
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_rpm <= 12'h000;
		end else begin
			o_rpm <= rpm_next;
		end
	end

endmodule

// file: hdl/rost_top.sv
// rost_top: relay outputs and tachometer acceleration trip with an apb slave.
// assumes synchronous inputs, a one-cycle manual reset pulse and one clock.
//
// Functional notes
// - each relay has its own fail-safe and latching selection
// - fail-safe relay energised when powered, drops on its event or power loss
// - non-latching relay releases by itself once its cause clears
// - latching relay holds until manual reset; trip relay latches by default
// - only relays five to eight may take second or third assignments
// - relays never block a start internally; interlock wiring does that
// - scale enable, default off, requests manual rpm scale points
// - low scale point rpm, default 0, range 0 to 3600
// - high scale point rpm, default 2000, range 0 to 3600
// - trip mode underspeed, overspeed or disabled; disabled never trips
// - underspeed mode uses only the underspeed point
// - overspeed mode uses only the overspeed point
// - ramp time before sampling, default 20 s, range 1 to 120
// - underspeed trip when sample below point, default 1650, range 0 to 3600
// - overspeed trip when sample above point, default 1850, range 0 to 3600
// - trip asserted after condition persists delay, default 1 s, range 1 to 60
// - trip functions drive trip relay, alarm functions drive alarm relay
module rost_top #(
	parameter int unsigned P_SEC_CYCLES = rost_pkg::SEC_CYCLES
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// protection inputs
	input  wire logic        i_trip_func,
	input  wire logic        i_alarm_func,
	input  wire logic        i_factory_three_cond,
	input  wire logic        i_factory_four_cond,
	input  wire logic [3:0]  i_user_cond,
	input  wire logic        i_motor_start,
	input  wire logic [11:0] i_speed_code,
	input  wire logic        i_manual_reset,
	// outputs
	output logic      [7:0]  o_relay_coil,
	output logic             o_tach_trip,
	output logic             o_scale_prompt,
	output logic             o_irq
);
	import rost_pkg::*;

	// clamp a written value into its legal range
	function automatic logic [11:0] clamp12(input logic [11:0] v, input logic [11:0] lo,
	                                        input logic [11:0] hi);
		clamp12 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// configuration registers
	logic [7:0]  fail_safe_reg;
	logic [7:0]  latch_reg;
	logic        scale_en_reg;
	logic [1:0]  mode_reg;
	logic [11:0] scale_lo_reg;
	logic [11:0] scale_hi_reg;
	logic [6:0]  ramp_reg;
	logic [11:0] under_pt_reg;
	logic [11:0] over_pt_reg;
	logic [6:0]  trip_dly_reg;
	logic [7:0]  route_reg;
	logic [2:0]  int_stat_reg;
	logic [2:0]  int_mask_reg;
	logic [11:0] sample_reg;

	// apb decode
	logic        wr_w;
	logic        setup_w;
	logic        hit_w;
	logic [31:0] rdata_w;
	logic [11:0] wdata12_w;

	assign wr_w      = i_psel & i_penable & o_pready & i_pwrite;
	assign setup_w   = i_psel & ~i_penable;
	// second counts are clamped on the low twelve bits, so a count up to 4095 saturates, not wraps
	assign wdata12_w = i_pwdata[11:0];

	// status wires
	logic [7:0]  relay_cond_w;
	logic [7:0]  relay_active_w;
	logic [7:0]  relay_active_q;
	logic [11:0] rpm_w;
	logic [11:0] eff_lo_w;
	logic [11:0] eff_hi_w;

	assign hit_w = (i_paddr == OFS_RELAY_CFG) | (i_paddr == OFS_TACH_CFG) |
	               (i_paddr == OFS_SCALE_LO)  | (i_paddr == OFS_SCALE_HI) |
	               (i_paddr == OFS_RAMP)      | (i_paddr == OFS_UNDER_PT) |
	               (i_paddr == OFS_OVER_PT)   | (i_paddr == OFS_TRIP_DLY) |
	               (i_paddr == OFS_ROUTE)     | (i_paddr == OFS_STATUS)   |
	               (i_paddr == OFS_SAMPLE)    | (i_paddr == OFS_INT_STAT) |
	               (i_paddr == OFS_INT_MASK);

	// read mux; unmapped addresses read zero and flag an error
	assign rdata_w =
		(i_paddr == OFS_RELAY_CFG) ? {16'h0000, latch_reg, fail_safe_reg} :
		(i_paddr == OFS_TACH_CFG)  ? {29'h0000_0000, mode_reg, scale_en_reg} :
		(i_paddr == OFS_SCALE_LO)  ? {20'h0_0000, scale_lo_reg} :
		(i_paddr == OFS_SCALE_HI)  ? {20'h0_0000, scale_hi_reg} :
		(i_paddr == OFS_RAMP)      ? {25'h000_0000, ramp_reg} :
		(i_paddr == OFS_UNDER_PT)  ? {20'h0_0000, under_pt_reg} :
		(i_paddr == OFS_OVER_PT)   ? {20'h0_0000, over_pt_reg} :
		(i_paddr == OFS_TRIP_DLY)  ? {25'h000_0000, trip_dly_reg} :
		(i_paddr == OFS_ROUTE)     ? {24'h00_0000, route_reg} :
		(i_paddr == OFS_STATUS)    ? {4'h0, rpm_w, relay_active_q, o_relay_coil} :
		(i_paddr == OFS_SAMPLE)    ? {20'h0_0000, sample_reg} :
		(i_paddr == OFS_INT_STAT)  ? {29'h0000_0000, int_stat_reg} :
		(i_paddr == OFS_INT_MASK)  ? {29'h0000_0000, int_mask_reg} :
		32'h0000_0000;

	// no wait state: answer is loaded in setup and shown in the first access cycle
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= setup_w;
			o_prdata  <= setup_w ? rdata_w : 32'h0000_0000;
			o_pslverr <= setup_w & ~hit_w;
		end
	end

	// configuration writes, clamped to the legal ranges
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			fail_safe_reg <= RST_FAILSAFE;
			latch_reg     <= RST_LATCH;
			scale_en_reg  <= 1'b0;
			mode_reg      <= MODE_DISABLED;
			scale_lo_reg  <= RST_SCALE_LO;
			scale_hi_reg  <= RST_SCALE_HI;
			ramp_reg      <= RST_RAMP;
			under_pt_reg  <= RST_UNDER_PT;
			over_pt_reg   <= RST_OVER_PT;
			trip_dly_reg  <= RST_TRIP_DLY;
			route_reg     <= RST_ROUTE;
			int_mask_reg  <= 3'h0;
		end else if (wr_w) begin
			case (i_paddr)
				OFS_RELAY_CFG: begin
					fail_safe_reg <= i_pwdata[RELAY_CFG_FS_LSB +: 8];
					latch_reg     <= i_pwdata[RELAY_CFG_LAT_LSB +: 8];
				end
				OFS_TACH_CFG: begin
					scale_en_reg <= i_pwdata[TACH_CFG_SCALE];
					mode_reg     <= (i_pwdata[TACH_CFG_MODE_LSB +: 2] == 2'h3) ? MODE_DISABLED
					                : i_pwdata[TACH_CFG_MODE_LSB +: 2];
				end
				OFS_SCALE_LO: scale_lo_reg <= clamp12(wdata12_w, 12'h000, RPM_MAX);
				OFS_SCALE_HI: scale_hi_reg <= clamp12(wdata12_w, 12'h000, RPM_MAX);
				OFS_RAMP:     ramp_reg <= 7'(clamp12(wdata12_w,
				                              {5'h00, RAMP_MIN}, {5'h00, RAMP_MAX}));
				OFS_UNDER_PT: under_pt_reg <= clamp12(wdata12_w, 12'h000, RPM_MAX);
				OFS_OVER_PT:  over_pt_reg  <= clamp12(wdata12_w, 12'h000, RPM_MAX);
				OFS_TRIP_DLY: trip_dly_reg <= 7'(clamp12(wdata12_w,
				                              {5'h00, DLY_MIN}, {5'h00, DLY_MAX}));
				// first four relays are factory reserved: only user routes are writable
				OFS_ROUTE:    route_reg[ROUTE_USER_LSB +: 4] <= i_pwdata[ROUTE_USER_LSB +: 4];
				OFS_INT_MASK: int_mask_reg <= i_pwdata[2:0];
				default: ;
			endcase
		end
	end

	// scale points fall back to factory values until manual scaling is enabled
	assign eff_lo_w = scale_en_reg ? scale_lo_reg : RST_SCALE_LO;
	assign eff_hi_w = scale_en_reg ? scale_hi_reg : RST_SCALE_HI;

	rost_rpm_scale u_scale (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_code    (i_speed_code),
		.i_rpm_lo  (eff_lo_w),
		.i_rpm_hi  (eff_hi_w),
		.o_rpm     (rpm_w)
	);

	// one-second time base; parameter lets simulation shorten it
	logic [31:0] div_reg;
	logic        tick_w;

	assign tick_w = (div_reg == 32'(P_SEC_CYCLES - 1));

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || tick_w) begin
			div_reg <= 32'h0000_0000;
		end else begin
			div_reg <= div_reg + 32'h0000_0001;
		end
	end

	// tach acceleration check: ramp, single sample, persistence, trip
	rost_tach_t  st_reg;
	rost_tach_t  st_next;
	logic [6:0]  sec_reg;
	logic        cond_w;
	logic        sample_cond_w;
	logic        ramp_done_w;
	logic        dly_done_w;
	logic        mode_on_w;

	assign mode_on_w     = (mode_reg == MODE_UNDER) | (mode_reg == MODE_OVER);
	assign cond_w        = ((mode_reg == MODE_UNDER) & (rpm_w < under_pt_reg)) |
	                       ((mode_reg == MODE_OVER) & (rpm_w > over_pt_reg));
	assign sample_cond_w = ((mode_reg == MODE_UNDER) & (sample_reg < under_pt_reg)) |
	                       ((mode_reg == MODE_OVER) & (sample_reg > over_pt_reg));
	assign ramp_done_w   = tick_w & (sec_reg + 7'h01 >= ramp_reg);
	assign dly_done_w    = tick_w & (sec_reg + 7'h01 >= trip_dly_reg);

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE:    st_next = (i_motor_start & mode_on_w) ? ST_RAMP : ST_IDLE;
			ST_RAMP:    st_next = ramp_done_w ? ST_SAMPLE : ST_RAMP;
			ST_SAMPLE:  st_next = cond_w ? ST_PERSIST : ST_DONE;
			ST_PERSIST: st_next = !sample_cond_w ? ST_DONE :
			                      (dly_done_w ? ST_TRIPPED : ST_PERSIST);
			ST_TRIPPED: st_next = ST_TRIPPED;
			ST_DONE:    st_next = ST_DONE;
			default:    st_next = ST_IDLE;
		endcase
		// dropping the start or disabling the check ends the sequence
		if (!i_motor_start || !mode_on_w) begin
			st_next = ST_IDLE;
		end
	end

	// seconds counter restarts on every state change
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_reg     <= ST_IDLE;
			sec_reg    <= 7'h00;
			sample_reg <= 12'h000;
		end else begin
			st_reg     <= st_next;
			sec_reg    <= (st_next != st_reg) ? 7'h00 : (tick_w ? sec_reg + 7'h01 : sec_reg);
			sample_reg <= (st_reg == ST_SAMPLE) ? rpm_w : sample_reg;
		end
	end

	// relay conditions; no output here inhibits a start, only wiring can
	logic tach_trip_w;

	assign tach_trip_w = (st_reg == ST_TRIPPED);
	assign relay_cond_w[RELAY_TRIP]  = i_trip_func | (tach_trip_w & route_reg[ROUTE_TRIP]);
	assign relay_cond_w[RELAY_ALARM] = i_alarm_func;
	assign relay_cond_w[RELAY_FACT3] = i_factory_three_cond;
	assign relay_cond_w[RELAY_FACT4] = i_factory_four_cond;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_user
			assign relay_cond_w[4 + g] = i_user_cond[g] |
			                             (tach_trip_w & route_reg[ROUTE_USER_LSB + g]);
		end
		for (g = 0; g < 8; g++) begin : g_relay
			rost_relay_chan u_chan (
				.i_clk_sys   (i_clk_sys),
				.i_sys_rst   (i_sys_rst),
				.i_cond      (relay_cond_w[g]),
				.i_fail_safe (fail_safe_reg[g]),
				.i_latch     (latch_reg[g]),
				.i_man_rst   (i_manual_reset),
				.o_active    (relay_active_w[g]),
				.o_coil      (o_relay_coil[g])
			);
		end
	endgenerate

	// sticky events; a new event wins over a clear written in the same cycle
	logic [2:0] ev_w;
	logic [2:0] clr_w;

	assign ev_w[IRQ_TACH_TRIP] = tach_trip_w & ~o_tach_trip;
	assign ev_w[IRQ_SAMPLE]    = (st_reg == ST_SAMPLE);
	assign ev_w[IRQ_RELAY]     = |(relay_active_w & ~relay_active_q);
	assign clr_w = (wr_w && i_paddr == OFS_INT_STAT) ? i_pwdata[2:0] : 3'h0;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			int_stat_reg   <= 3'h0;
			relay_active_q <= 8'h00;
			o_tach_trip    <= 1'b0;
			o_scale_prompt <= 1'b0;
			o_irq          <= 1'b0;
		end else begin
			int_stat_reg   <= (int_stat_reg & ~clr_w) | ev_w;
			relay_active_q <= relay_active_w;
			o_tach_trip    <= tach_trip_w;
			o_scale_prompt <= scale_en_reg;
			o_irq          <= |(((int_stat_reg & ~clr_w) | ev_w) & int_mask_reg);
		end
	end

endmodule

// file: testbench/rost_top_monitor.sv
// rost_top_monitor: port-level assertions for the relay and speed trip block.
// assumes the apb master holds each request until pready is sampled high.
module rost_top_monitor
	import rost_pkg::*;
#(
	parameter int unsigned P_SEC_CYCLES = 20
) (
	input wire logic        i_clk_sys,
	input wire logic        i_sys_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [7:0]  i_paddr,
	input wire logic        i_motor_start,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [7:0]  o_relay_coil,
	input wire logic        o_tach_trip
);
	// one apb transfer: setup, then a single answer cycle
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_answer;
		o_pready ##1 !o_pready;
	endsequence

	// bus answers
	a_ready_after_setup: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		s_setup |=> s_answer) else $error("pready missing after setup");
	a_ready_one_cycle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_pready |=> !o_pready) else $error("pready held too long");
	a_error_decode: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_pready |-> o_pslverr == (i_paddr > OFS_INT_MASK || i_paddr[1:0] != 2'h0))
		else $error("pslverr does not match address decode");
	a_error_with_ready: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_pslverr |-> o_pready) else $error("pslverr outside answer cycle");
	a_rdata_idle_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!o_pready |-> o_prdata == 32'h0000_0000) else $error("read data outside answer");

	// no disable here: the reset itself is the cause being checked
	a_reset_coils_off: assert property (@(posedge i_clk_sys)
		i_sys_rst |=> o_relay_coil == 8'h00) else $error("coil energised in reset");

	// speed trip only while a start is running, and never right at its start
	a_trip_drops_stop: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_motor_start [*3] |=> !o_tach_trip) else $error("speed trip without start");
	a_trip_after_ramp: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		$rose(o_tach_trip) |-> $past(i_motor_start, 3)) else $error("speed trip too early");
endmodule

bind rost_top rost_top_monitor #(.P_SEC_CYCLES(P_SEC_CYCLES)) rost_top_monitor_inst (
	.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_paddr(i_paddr), .i_motor_start(i_motor_start), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_relay_coil(o_relay_coil),
	.o_tach_trip(o_tach_trip));

// file: testbench/rost_field_model.sv
// rost_field_model: operator panel, speed transmitter and relay contacts.
// assumes the bench holds the panel request for at least two cycles.
module rost_field_model (
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_req,
	input  wire logic [11:0] i_speed_set,
	input  wire logic [7:0]  i_relay_coil,
	output logic             o_manual_reset,
	output logic      [11:0] o_speed_code,
	output logic      [7:0]  o_contact
);
	timeunit 1ns;
	timeprecision 1ps;
	logic req_q;

	// panel button gives one pulse per press; transmitter is sampled each cycle
	always_ff @(posedge i_clk_sys) begin
		req_q          <= i_reset_req;
		o_manual_reset <= i_reset_req & ~req_q;
		o_speed_code   <= i_speed_set;
	end

	// normally open contacts close while the coil is energised
	assign o_contact = i_relay_coil;
endmodule

// file: testbench/tb_rost_top.sv
// tb_rost_top: directed bench for the relay output and speed trip block.
// assumes a 125 MHz clock, a synchronous reset and a zero-wait apb slave.
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("mismatch at %0t got %h expected %h", $time, (a), (e)); end end
module tb_rost_top;
	import rost_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned SEC = 20; // short second keeps the run brief
	logic        clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, coil, contact;
	logic [31:0] pwdata, prdata;
	logic        trip_f, alarm_f, f3, f4, motor, man_rst, req, tach_trip, prompt, irq;
	logic [3:0]  user;
	logic [11:0] code, spd_set;
	int          mismatches = 0;
	int          total_checks = 0;
	int          cycles = 0;

	rost_top #(.P_SEC_CYCLES(SEC)) rost_top_inst (.i_clk_sys(clk), .i_sys_rst(rst),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_trip_func(trip_f), .i_alarm_func(alarm_f), .i_factory_three_cond(f3),
		.i_factory_four_cond(f4), .i_user_cond(user), .i_motor_start(motor),
		.i_speed_code(code), .i_manual_reset(man_rst), .o_relay_coil(coil),
		.o_tach_trip(tach_trip), .o_scale_prompt(prompt), .o_irq(irq));
	rost_field_model rost_field_model_inst (.i_clk_sys(clk), .i_reset_req(req),
		.i_speed_set(spd_set), .i_relay_coil(coil), .o_manual_reset(man_rst),
		.o_speed_code(code), .o_contact(contact));

	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			complete_run;
		end
	end

	task automatic complete_run;
		if (mismatches == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one transfer, entered just after a rising edge; an idle cycle follows
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// pready high ends this wait, else only the bench timeout does; pready is read as it stood at the edge
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		`CHK(e, 1'b0)
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		`CHK({e, q & m}, {1'b0, x})
	endtask

	task automatic t_defaults;
		logic [7:0]  a [9] = '{OFS_RELAY_CFG, OFS_TACH_CFG, OFS_SCALE_LO, OFS_SCALE_HI,
			OFS_RAMP, OFS_UNDER_PT, OFS_OVER_PT, OFS_TRIP_DLY, OFS_ROUTE};
		logic [31:0] v [9] = '{32'h0000_0100, 32'h0000_0000, 32'h0000_0000, 32'h0000_07D0,
			32'h0000_0014, 32'h0000_0672, 32'h0000_073A, 32'h0000_0001, 32'h0000_0001};
		logic [31:0] q;
		logic        e;
		for (int i = 0; i < 9; i++) begin
			rd_chk(a[i], v[i], 32'hFFFF_FFFF);
		end
		apb(1'b0, 8'h34, 32'h0000_0000, q, e);
		`CHK({e, q}, {1'b1, 32'h0000_0000})
	endtask

	// out-of-range writes clamp; fixed fields keep their value
	task automatic t_limits;
		logic [7:0]  a [7] = '{OFS_RAMP, OFS_RAMP, OFS_TRIP_DLY, OFS_SCALE_HI,
			OFS_UNDER_PT, OFS_TACH_CFG, OFS_ROUTE};
		logic [11:0] w [7] = '{12'h000, 12'h0C8, 12'h050, 12'hFFF, 12'hFFF, 12'h006, 12'h0F0};
		logic [11:0] x [7] = '{12'h001, 12'h078, 12'h03C, 12'hE10, 12'hE10, 12'h000, 12'h0F1};
		for (int i = 0; i < 7; i++) begin
			wr(a[i], {20'h0_0000, w[i]});
			rd_chk(a[i], {20'h0_0000, x[i]}, 32'hFFFF_FFFF);
		end
		wr(OFS_SCALE_HI, 32'h0000_07D0);
		wr(OFS_UNDER_PT, 32'h0000_0672);
		wr(OFS_RAMP, 32'h0000_0002);
		wr(OFS_TRIP_DLY, 32'h0000_0001);
	endtask

	// apply conditions and an optional panel reset, then look at the contacts
	task automatic step(input logic [3:0] u, input logic [2:0] f, input logic m,
			input logic [7:0] x);
		user <= u;
		trip_f <= f[2];
		alarm_f <= f[1];
		f3 <= f[0];
		req <= m;
		tick(2);
		req <= 1'b0;
		tick(3);
		`CHK(contact, x)
	endtask

	task automatic t_relays;
		wr(OFS_RELAY_CFG, 32'h0000_2110); // relay five fail-safe, relay six latching
		tick(3);
		`CHK(contact, 8'h10)
		step(4'h1, 3'h0, 1'b0, 8'h00);
		step(4'h2, 3'h0, 1'b0, 8'h30);
		step(4'h0, 3'h0, 1'b0, 8'h30);
		step(4'h2, 3'h0, 1'b1, 8'h30);
		step(4'h0, 3'h0, 1'b1, 8'h10);
		step(4'h4, 3'h0, 1'b0, 8'h50);
		step(4'h0, 3'h0, 1'b0, 8'h10);
		step(4'h0, 3'h4, 1'b0, 8'h11);
		step(4'h0, 3'h2, 1'b0, 8'h13);
		step(4'h0, 3'h0, 1'b0, 8'h11);
		step(4'h8, 3'h1, 1'b1, 8'h94);
		wr(OFS_RELAY_CFG, 32'h0000_0100);
		step(4'h0, 3'h0, 1'b0, 8'h00);
	endtask

	task automatic t_rpm(input logic [11:0] c, input logic [11:0] r);
		spd_set <= c;
		tick(6);
		rd_chk(OFS_STATUS, {4'h0, r, 16'h0000}, 32'h0FFF_0000);
	endtask

	task automatic t_scale;
		t_rpm(12'hFFF, 12'h7D0);
		t_rpm(12'h800, 12'h3E8);
		wr(OFS_SCALE_LO, 32'h0000_0064);
		wr(OFS_SCALE_HI, 32'h0000_0C1C);
		t_rpm(12'hFFF, 12'h7D0);
		wr(OFS_TACH_CFG, 32'h0000_0001);
		tick(3);
		`CHK(prompt, 1'b1)
		t_rpm(12'h000, 12'h064);
		t_rpm(12'hFFF, 12'hC1C);
		t_rpm(12'h800, 12'h640);
		wr(OFS_TACH_CFG, 32'h0000_0000);
		wr(OFS_SCALE_LO, 32'h0000_0000);
		wr(OFS_SCALE_HI, 32'h0000_07D0);
	endtask

	// ramp of two seconds, delay of one: no trip may come inside the first second
	task automatic t_accel(input logic [1:0] m, input logic [11:0] c, input logic [11:0] r,
			input logic x);
		int n;
		n = 0;
		spd_set <= c;
		wr(OFS_TACH_CFG, {29'h0000_0000, m, 1'b0});
		motor <= 1'b1;
		while (tach_trip !== 1'b1 && n < 120) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		`CHK(tach_trip, x)
		`CHK(contact[7:4], {4{x}})
		`CHK(x && n < 21, 1'b0)
		if (m != MODE_DISABLED) begin
			rd_chk(OFS_SAMPLE, {20'h0_0000, r}, 32'h0000_0FFF);
		end
		motor <= 1'b0;
		tick(4);
		`CHK(tach_trip, 1'b0)
	endtask

	task automatic t_irq;
		wr(OFS_INT_MASK, 32'h0000_0000);
		tick(3);
		`CHK(irq, 1'b0)
		wr(OFS_INT_MASK, 32'h0000_0007);
		tick(3);
		`CHK(irq, 1'b1)
		wr(OFS_INT_STAT, 32'h0000_0007);
		tick(3);
		`CHK(irq, 1'b0)
		rd_chk(OFS_INT_STAT, 32'h0000_0000, 32'h0000_0007);
		`CHK(contact[0], 1'b1)
		step(4'h0, 3'h0, 1'b1, 8'h00);
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{trip_f, alarm_f, f3, f4, user, motor, req} = '0;
		spd_set = 12'h000;
		tick(20);
		rst <= 1'b0;
		tick(1);
		t_defaults;
		t_limits;
		t_relays;
		t_scale;
		t_accel(MODE_DISABLED, 12'h800, 12'h3E8, 1'b0);
		t_accel(MODE_UNDER, 12'h800, 12'h3E8, 1'b1);
		t_accel(MODE_UNDER, 12'hFFF, 12'h7D0, 1'b0);
		t_accel(MODE_OVER, 12'hFFF, 12'h7D0, 1'b1);
		t_accel(MODE_OVER, 12'h800, 12'h3E8, 1'b0);
		t_irq;
		complete_run;
	end
endmodule
